// *** core/cpu_interrupt_enable_gating.sv ***
// enable masks and request gating for the maskable cpu interrupt lines
// assumes the cpu core issues register ops and service events on clock
//
// What this block does
// - level enable bits 13..0 gate levels 14..1, one enables, zero disables
// - debug enable register matters only while halted in real-time mode
// - halted real-time: serve only lines set in both enable registers
// - running real-time: normal handling, debug enable register ignored
// - reset clears all sixteen debug enable bits
// - debug enable bits read and write; one enables, zero disables
// - debug layout: bit 15 rtos, bit 14 data log, 13..0 levels
// - debug register read by push, written by pop only
// - reset clears all level enable bits
// - acknowledge enabled line only if pending and, while running, global mask clear; halted real-time ignores the global mask
// - hardware service or software irq clears its enable bit; trap does not
// - nmi and reset bypass the enable gating entirely
`timescale 1ns/1ps
module cpu_interrupt_enable_gating (
    input wire logic clock,
    input wire logic rst,
    input wire irq_gate_pkg::reg_req_s reg_req,
    input wire irq_gate_pkg::service_s service,
    input wire logic [15:0] pending_flag_register,
    input wire logic global_irq_mask,
    input wire logic halted_rt,
    input wire logic nmi_request,
    output logic [15:0] level_enable_register,
    output logic [15:0] debug_enable_register,
    output logic [15:0] gated_request,
    output logic nmi_out
);
    logic [15:0] level_r;
    logic [15:0] level_nxt;
    logic [15:0] debug_r;
    logic [15:0] grant;
    logic [15:0] gated_r;
    logic nmi_r;
    logic [15:0] clear_mask;

    // service clear: hardware and software irq clear their bit, a trap keeps it
    always_comb begin
        clear_mask = 16'h0000;
        if (service.valid && service.kind != irq_gate_pkg::SVC_TRAP) begin
            clear_mask[service.line] = 1'b1;
        end
    end

    // level register next value; a write in the service cycle is applied first
    always_comb begin
        level_nxt = level_r;
        if (reg_req.valid) begin
            case (reg_req.op)
                irq_gate_pkg::OPC_LEVEL_WRITE: level_nxt = reg_req.data;
                irq_gate_pkg::OPC_LEVEL_OR: level_nxt = level_r | reg_req.data;
                irq_gate_pkg::OPC_LEVEL_AND: level_nxt = level_r & reg_req.data;
                default: level_nxt = level_r;
            endcase
        end
        level_nxt = level_nxt & ~clear_mask;
    end

    // level enable register
    always_ff @(posedge clock) begin
        if (rst) begin
            level_r <= irq_gate_pkg::LEVEL_ENABLE_RESET;
        end else begin
            level_r <= level_nxt;
        end
    end

    // debug enable register, written only by the pop operation
    always_ff @(posedge clock) begin
        if (rst) begin
            debug_r <= irq_gate_pkg::DEBUG_ENABLE_RESET;
        end else if (reg_req.valid && reg_req.op == irq_gate_pkg::OPC_DEBUG_POP) begin
            debug_r <= reg_req.data;
        end
    end

    // per line gating, same bit layout in both registers
    for (genvar i = 0; i < irq_gate_pkg::NUM_LINES; i++) begin : g_line
        line_gate u_gate (
            .pending(pending_flag_register[i]),
            .level_en(level_r[i]),
            .debug_en(debug_r[i]),
            .halted_rt(halted_rt),
            .mask_set(global_irq_mask),
            .grant(grant[i])
        );
    end

    // registered outputs; nmi passes around the masks with matching latency
    always_ff @(posedge clock) begin
        if (rst) begin
            gated_r <= 16'h0000;
            nmi_r <= 1'b0;
        end else begin
            gated_r <= grant;
            nmi_r <= nmi_request;
        end
    end

    assign level_enable_register = level_r;
    assign debug_enable_register = debug_r;
    assign gated_request = gated_r;
    assign nmi_out = nmi_r;

    // both masks come out of reset cleared
    property p_reset_clears;
        @(posedge clock) rst |=> (level_r == 16'h0000 && debug_r == 16'h0000);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("reset did not clear enables");

    // reset also drops the registered request and nmi outputs
    property p_reset_outputs;
        @(posedge clock) rst |=> (gated_request == 16'h0000 && !nmi_out);
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("reset did not clear outputs");

    // the !rst terms are sampled: the edge that releases reset still resets, so it must not start a check
    property p_halted_gate;
        @(posedge clock) disable iff (rst)
        (!rst && halted_rt) |=> gated_r == $past(pending_flag_register & level_r & debug_r);
    endproperty
    a_halted_gate: assert property (p_halted_gate) else $error("halted gating wrong");

    // halted, a line without its debug bit never passes
    property p_halted_debug;
        @(posedge clock) disable iff (rst) (!rst && halted_rt) |=> (gated_r & ~$past(debug_r)) == 16'h0000;
    endproperty
    a_halted_debug: assert property (p_halted_debug) else $error("halted line passed without debug bit");

    // running, the debug mask has no say and the global mask does
    property p_run_gate;
        @(posedge clock) disable iff (rst)
        (!rst && !halted_rt) |=>
        gated_r == ($past(global_irq_mask) ? 16'h0000 : $past(pending_flag_register & level_r));
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("running gating wrong");

    // a set global mask blocks every line while running
    property p_mask_blocks;
        @(posedge clock) disable iff (rst) (!rst && !halted_rt && global_irq_mask) |=> gated_r == 16'h0000;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked line granted");

    // a disabled line is never granted, whatever the mode
    property p_disabled_never;
        @(posedge clock) disable iff (rst) 1'b1 |=> (gated_r & ~$past(level_r)) == 16'h0000;
    endproperty
    a_disabled_never: assert property (p_disabled_never) else $error("disabled line granted");

    // hardware service and software irq clear the served bit, even over a same-cycle write
    sequence s_hw_service;
        service.valid && service.kind != irq_gate_pkg::SVC_TRAP;
    endsequence
    property p_service_clear;
        @(posedge clock) disable iff (rst) s_hw_service |=> !level_r[$past(service.line)];
    endproperty
    a_service_clear: assert property (p_service_clear) else $error("service did not clear enable");

    // a trap leaves the enables alone
    property p_trap_keeps;
        @(posedge clock) disable iff (rst)
        (!rst && service.valid && service.kind == irq_gate_pkg::SVC_TRAP && !reg_req.valid) |=> $stable(level_r);
    endproperty
    a_trap_keeps: assert property (p_trap_keeps) else $error("trap changed enables");

    // level ops: whole write, or-in and and-out, checked only in cycles with no service event
    sequence s_level_write;
        !rst && reg_req.valid && !service.valid && reg_req.op == irq_gate_pkg::OPC_LEVEL_WRITE;
    endsequence
    property p_level_write;
        @(posedge clock) disable iff (rst) s_level_write |=> level_r == $past(reg_req.data);
    endproperty
    a_level_write: assert property (p_level_write) else $error("level write not stored");

    sequence s_level_or;
        !rst && reg_req.valid && !service.valid && reg_req.op == irq_gate_pkg::OPC_LEVEL_OR;
    endsequence
    property p_level_or;
        @(posedge clock) disable iff (rst) s_level_or |=> level_r == ($past(level_r) | $past(reg_req.data));
    endproperty
    a_level_or: assert property (p_level_or) else $error("level or wrong");

    sequence s_level_and;
        !rst && reg_req.valid && !service.valid && reg_req.op == irq_gate_pkg::OPC_LEVEL_AND;
    endsequence
    property p_level_and;
        @(posedge clock) disable iff (rst) s_level_and |=> level_r == ($past(level_r) & $past(reg_req.data));
    endproperty
    a_level_and: assert property (p_level_and) else $error("level and wrong");

    // unknown op codes leave both masks alone
    sequence s_unknown_op;
        !rst && reg_req.valid && !service.valid &&
            (reg_req.op == 3'h0 || reg_req.op > irq_gate_pkg::OPC_DEBUG_POP);
    endsequence
    property p_unknown_op;
        @(posedge clock) disable iff (rst) s_unknown_op |=> ($stable(level_r) && $stable(debug_r));
    endproperty
    a_unknown_op: assert property (p_unknown_op) else $error("unknown op changed a mask");

    // only the pop op reaches the debug mask, and it stores the value whole
    property p_pop_only;
        @(posedge clock) disable iff (rst)
        (!rst && !(reg_req.valid && reg_req.op == irq_gate_pkg::OPC_DEBUG_POP)) |=> $stable(debug_r);
    endproperty
    a_pop_only: assert property (p_pop_only) else $error("debug register changed without pop");

    property p_pop_write;
        @(posedge clock) disable iff (rst)
        (!rst && reg_req.valid && reg_req.op == irq_gate_pkg::OPC_DEBUG_POP) |=> debug_r == $past(reg_req.data);
    endproperty
    a_pop_write: assert property (p_pop_write) else $error("pop value not stored");

    // nmi bypasses the masks and follows its input both ways
    property p_nmi_bypass;
        @(posedge clock) disable iff (rst) (!rst && nmi_request) |=> nmi_out;
    endproperty
    a_nmi_bypass: assert property (p_nmi_bypass) else $error("nmi was gated");

    property p_nmi_follow;
        @(posedge clock) disable iff (rst) !rst |=> nmi_out == $past(nmi_request);
    endproperty
    a_nmi_follow: assert property (p_nmi_follow) else $error("nmi output lost its input");
endmodule // cpu_interrupt_enable_gating

// *** core/irq_gate_pkg.sv ***
// shared constants and carriers for the cpu interrupt enable gating block
// assumes the cpu core drives register ops and the service sequencer on one clock
package irq_gate_pkg;
    localparam int NUM_LINES = 16;
    localparam int LEVEL_LO_BIT = 0;
    localparam int LEVEL_HI_BIT = 13;
    localparam int DATA_LOG_BIT = 14;
    localparam int RTOS_BIT = 15;
    localparam logic [15:0] LEVEL_ENABLE_RESET = 16'h0000;
    localparam logic [15:0] DEBUG_ENABLE_RESET = 16'h0000;

    // register operations the cpu core issues on the enable registers
    typedef enum {
        OP_NONE,
        OP_LEVEL_WRITE,
        OP_LEVEL_OR,
        OP_LEVEL_AND,
        OP_DEBUG_POP
    } reg_op_e;

    // one register request from the cpu core
    typedef struct packed {
        logic valid;
        logic [2:0] op;
        logic [15:0] data;
    } reg_req_s;

    // one service event from the acknowledge sequencer
    typedef struct packed {
        logic valid;
        logic [1:0] kind;
        logic [3:0] line;
    } service_s;

    localparam logic [2:0] OPC_LEVEL_WRITE = 3'h1;
    localparam logic [2:0] OPC_LEVEL_OR = 3'h2;
    localparam logic [2:0] OPC_LEVEL_AND = 3'h3;
    localparam logic [2:0] OPC_DEBUG_POP = 3'h4;
    localparam logic [1:0] SVC_HARDWARE = 2'h0;
    localparam logic [1:0] SVC_SOFTWARE = 2'h1;
    localparam logic [1:0] SVC_TRAP = 2'h2;
endpackage

// *** core/line_gate.sv ***
// per-line gating of one pending request by the two enables and the mode
// assumes all inputs are registered or same-clock logic
`timescale 1ns/1ps
module line_gate (
    input wire logic pending,
    input wire logic level_en,
    input wire logic debug_en,
    input wire logic halted_rt,
    input wire logic mask_set,
    output logic grant
);
    // halted real-time mode ignores the global mask and needs both enables
    always_comb begin
        if (halted_rt) begin
            grant = pending && level_en && debug_en;
        end else begin
            grant = pending && level_en && !mask_set;
        end
    end
endmodule // line_gate

// *** bench/service_model.sv ***
// cpu acknowledge sequencer model: serves the lowest granted line once per go
// assumes go is held high until the bench has seen the service land
`timescale 1ns/1ps
module service_model (
    input wire logic clock,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [15:0] gated_request,
    output irq_gate_pkg::service_s service
);
    logic busy_r;

    // one event per go, so a trap that leaves its bit set cannot repeat
    always_ff @(posedge clock) begin
        service <= '0;
        if (rst || !go) begin
            busy_r <= 1'b0;
        end else if (!busy_r && gated_request != 16'h0000) begin
            busy_r <= 1'b1;
            service.valid <= 1'b1;
            service.kind <= kind;
            for (int i = 15; i >= 0; i--) begin
                if (gated_request[i]) service.line <= 4'(i);
            end
        end
    end
endmodule // service_model

// *** bench/cpu_interrupt_enable_gating_tb.sv ***
// self-checking bench for the interrupt enable gating block
// assumes the sequencer model serves granted lines on request
`timescale 1ns/1ps
`define chk(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", nm, e, s); end end
module cpu_interrupt_enable_gating_tb;
    logic clock, rst, mask, halted, nmi, go, nmi_out;
    logic [1:0] kind;
    logic [15:0] pend, lvl, dbg, gated;
    irq_gate_pkg::reg_req_s req;
    irq_gate_pkg::service_s svc;
    int n_fail = 0;
    int n_tests = 0;

    cpu_interrupt_enable_gating i_cpu_interrupt_enable_gating (.clock(clock), .rst(rst), .reg_req(req),
        .service(svc), .pending_flag_register(pend), .global_irq_mask(mask), .halted_rt(halted),
        .nmi_request(nmi), .level_enable_register(lvl), .debug_enable_register(dbg),
        .gated_request(gated), .nmi_out(nmi_out));
    service_model i_service_model (.clock(clock), .rst(rst), .go(go), .kind(kind),
        .gated_request(gated), .service(svc));

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task results;
        $display("checks %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one request cycle, then look once the register has taken it
    task op(input logic [2:0] o, input logic [15:0] d);
        @(posedge clock) req <= {1'b1, o, d};
        @(posedge clock) req <= '0;
        @(negedge clock);
    endtask

    // gated outputs trail their inputs by a register stage
    task settle;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    task t_reset;
        `chk("level", 16'h0000, lvl)
        `chk("debug", 16'h0000, dbg)
        `chk("gated", 16'h0000, gated)
        `chk("nmi", 1'b0, nmi_out)
    endtask

    // reset in mid-run drops both masks and the outputs, then the level mask is rebuilt
    task t_rerst;
        @(posedge clock) rst <= 1'b1;
        @(posedge clock) rst <= 1'b0;
        @(negedge clock);
        `chk("level", 16'h0000, lvl)
        `chk("debug", 16'h0000, dbg)
        `chk("gated", 16'h0000, gated)
        `chk("nmi", 1'b0, nmi_out)
        op(irq_gate_pkg::OPC_LEVEL_WRITE, 16'h4001);
        `chk("level", 16'h4001, lvl)
    endtask

    task t_regs;
        op(irq_gate_pkg::OPC_LEVEL_WRITE, 16'h0003);
        `chk("level", 16'h0003, lvl)
        op(irq_gate_pkg::OPC_LEVEL_OR, 16'hc000);
        `chk("level", 16'hc003, lvl)
        op(irq_gate_pkg::OPC_LEVEL_AND, 16'h4001);
        `chk("level", 16'h4001, lvl)
        op(3'h5, 16'hffff);
        `chk("debug", 16'h0000, dbg)
        op(irq_gate_pkg::OPC_DEBUG_POP, 16'h8001);
        `chk("debug", 16'h8001, dbg)
        `chk("level", 16'h4001, lvl)
    endtask

    // running: debug mask ignored, global mask honoured
    task t_run;
        @(posedge clock) pend <= 16'hffff;
        settle;
        `chk("gated", 16'h4001, gated)
        @(posedge clock) mask <= 1'b1;
        settle;
        `chk("gated", 16'h0000, gated)
    endtask

    // halted: only lines set in both masks pass
    task t_halt;
        @(posedge clock) halted <= 1'b1;
        settle;
        `chk("gated", 16'h0001, gated)
        @(posedge clock) nmi <= 1'b1;
        settle;
        `chk("nmi", 1'b1, nmi_out)
    endtask

    task serve(input logic [1:0] k, input logic [15:0] e);
        int i;
        @(posedge clock) begin
            kind <= k;
            go <= 1'b1;
        end
        for (i = 0; i < 20 && svc.valid !== 1'b1; i++) @(negedge clock);
        if (i == 20) begin
            `chk("service", 1'b1, svc.valid)
            results;
        end
        settle;
        `chk("level", e, lvl)
        @(posedge clock) go <= 1'b0;
    endtask

    task t_svc;
        @(posedge clock) begin
            halted <= 1'b0;
            mask <= 1'b0;
            pend <= 16'h0001;
        end
        serve(irq_gate_pkg::SVC_TRAP, 16'h4001);
        serve(irq_gate_pkg::SVC_SOFTWARE, 16'h4000);
        @(posedge clock) pend <= 16'h4000;
        serve(irq_gate_pkg::SVC_HARDWARE, 16'h0000);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        req = '0;
        pend = 16'h0000;
        {mask, halted, nmi, go} = 4'h0;
        kind = 2'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        t_reset;
        t_regs;
        t_run;
        t_halt;
        t_rerst;
        t_svc;
        results;
    end
endmodule // cpu_interrupt_enable_gating_tb
